// *** core/lpac_defines.svh ***
`ifndef LPAC_DEFINES_SVH
`define LPAC_DEFINES_SVH

// Register offsets on the management port
`define LPAC_OFF_ABILITY 5'h05
`define LPAC_OFF_STATUS 5'h10
`define LPAC_OFF_ENABLE 5'h11
`define LPAC_OFF_CLEAR 5'h12
`define LPAC_OFF_CONTROL 5'h13
`define LPAC_OFF_BASE_SHADOW 5'h14

// Field positions in the ability word
`define LPAC_BIT_NEXT_PAGE 15
`define LPAC_BIT_ACK 14
`define LPAC_BIT_REMOTE_FAULT 13
`define LPAC_BIT_MESSAGE_PAGE 13
`define LPAC_BIT_RESERVED 12
`define LPAC_BIT_COMPLY_ACK 12
`define LPAC_BIT_ASYM_PAUSE 11
`define LPAC_BIT_TOGGLE 11
`define LPAC_BIT_PAUSE 10
`define LPAC_BIT_FOUR_PAIR 9
`define LPAC_BIT_FAST_FD 8
`define LPAC_BIT_FAST 7
`define LPAC_BIT_SLOW_FD 6
`define LPAC_BIT_SLOW 5
`define LPAC_SEL_MSB 4
`define LPAC_CODE_MSB 10

// Event bits of the status register
`define LPAC_EV_BASE 0
`define LPAC_EV_NEXT 1
`define LPAC_EV_FAULT 2
`define LPAC_EV_DISCARD 3
`define LPAC_EV_VIEW 4
`define LPAC_EV_COUNT 5

// Control register fields
`define LPAC_CTRL_NEXT_EN 0

// Reset values
`define LPAC_RST_WORD 16'h0000
`define LPAC_RST_ENABLE 5'h00
`define LPAC_RST_NEXT_EN 1'b1

// Identical words needed before a word is taken
`define LPAC_MATCH_COUNT 3

`endif

// *** core/lpac_event_bit.sv ***
`timescale 1ns/1ps
module lpac_event_bit import lpac_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Set by hardware, cleared by software
    input wire logic set_pulse,
    input wire logic clr_pulse,
    // Sticky flag
    output logic flag
);

    lpac_event_s state_reg;
    lpac_event_s state_next;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        state_next = state_reg;
        if (set_pulse) begin
            state_next.flag = 1'b1;
        end else if (clr_pulse) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;

endmodule : lpac_event_bit

// *** core/lpac_partner_ability.sv ***
// How it works
// RQ1 - Partner ability word readable at offset 0x05, read only.
// RQ2 - With next pages enabled, next page replaces base page after completion.
// RQ3 - Bit 15 shows the partner's next page request in both views, reset 0.
// RQ4 - Bit 14 shows partner acknowledge, updated from received words, reset 0.
// RQ5 - Software should not write bit 14; writes to this offset are ignored.
// RQ6 - Bit 13 shows partner remote fault in the base view, reset 0.
// RQ7 - Bit 12 reads 0 in the base view; writers put 0 there.
// RQ8 - Bit 11 shows partner asymmetric pause ability, reset 0.
// RQ9 - Bit 10 shows partner symmetric pause ability, reset 0.
// RQ10 - Bit 9 shows partner four pair fast ability, reset 0.
// RQ11 - Bits 8 and 7 show fast full duplex and fast abilities, reset 0.
// RQ12 - Bits 6 and 5 show slow full duplex and slow abilities, reset 0.
// RQ13 - Bits 4 to 0 hold the partner selector as received, reset 0.
// RQ14 - Next view: bit 13 message page flag, bits 10 to 0 code field.
// RQ15 - Next view: bit 12 shows partner ability to comply with message.
// RQ16 - Next view: bit 11 holds the received toggle value.
// RQ17 - Register changes only after a complete consistently received word.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "lpac_defines.svh"
module lpac_partner_ability import lpac_pkg::*; #(
    parameter int MATCH_COUNT = `LPAC_MATCH_COUNT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Management register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Words decoded from the partner's pulse bursts
    input wire logic [15:0] rx_word,
    input wire logic rx_word_valid,
    // Negotiation progress from the arbitration logic
    input wire logic an_restart,
    input wire logic an_complete,
    // Status towards the rest of the device
    output logic view_next,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    lpac_main_s state_reg;
    lpac_main_s state_next;

    logic word_commit;
    logic [15:0] word_value;
    logic word_mismatch;
    logic [`LPAC_EV_COUNT-1:0] ev_set;
    logic [`LPAC_EV_COUNT-1:0] ev_clr;
    logic [`LPAC_EV_COUNT-1:0] ev_flag;
    logic [15:0] base_view;
    logic [15:0] next_view;
    logic [15:0] ability_word;
    logic clear_wr;
    logic switch_view;

    // The filter counter is eight bits wide; longer runs cannot be counted
    if (MATCH_COUNT < 1 || MATCH_COUNT > 255) begin : g_bad_count
        $error("MATCH_COUNT out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Word consistency filter

    // Bursts can be corrupted; only repeated identical words reach the bank
    lpac_word_match #(
        .MATCH_COUNT(MATCH_COUNT)
    ) u_match (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .word_valid(rx_word_valid),
        .word(rx_word),
        .restart(an_restart),
        .commit(word_commit),
        .commit_word(word_value),
        .mismatch(word_mismatch)
    );

    ////////////////////////////////////////////////////////////////////////
    // Views of the ability register

    // Base page layout, reserved bit forced low
    always_comb begin
        base_view = '0;
        base_view[`LPAC_BIT_NEXT_PAGE] = state_reg.base_page[`LPAC_BIT_NEXT_PAGE]; // [RQ3]
        base_view[`LPAC_BIT_ACK] = state_reg.base_page[`LPAC_BIT_ACK]; // [RQ4]
        base_view[`LPAC_BIT_REMOTE_FAULT] = state_reg.base_page[`LPAC_BIT_REMOTE_FAULT]; // [RQ6]
        base_view[`LPAC_BIT_RESERVED] = 1'b0; // [RQ7]
        base_view[`LPAC_BIT_ASYM_PAUSE] = state_reg.base_page[`LPAC_BIT_ASYM_PAUSE]; // [RQ8]
        base_view[`LPAC_BIT_PAUSE] = state_reg.base_page[`LPAC_BIT_PAUSE]; // [RQ9]
        base_view[`LPAC_BIT_FOUR_PAIR] = state_reg.base_page[`LPAC_BIT_FOUR_PAIR]; // [RQ10]
        base_view[`LPAC_BIT_FAST_FD] = state_reg.base_page[`LPAC_BIT_FAST_FD]; // [RQ11]
        base_view[`LPAC_BIT_FAST] = state_reg.base_page[`LPAC_BIT_FAST]; // [RQ11]
        base_view[`LPAC_BIT_SLOW_FD] = state_reg.base_page[`LPAC_BIT_SLOW_FD]; // [RQ12]
        base_view[`LPAC_BIT_SLOW] = state_reg.base_page[`LPAC_BIT_SLOW]; // [RQ12]
        base_view[`LPAC_SEL_MSB:0] = state_reg.base_page[`LPAC_SEL_MSB:0]; // [RQ13]
    end

    // Next page layout; every bit is meaningful here
    always_comb begin
        next_view = '0;
        next_view[`LPAC_BIT_NEXT_PAGE] = state_reg.next_page[`LPAC_BIT_NEXT_PAGE]; // [RQ3]
        next_view[`LPAC_BIT_ACK] = state_reg.next_page[`LPAC_BIT_ACK]; // [RQ4]
        next_view[`LPAC_BIT_MESSAGE_PAGE] = state_reg.next_page[`LPAC_BIT_MESSAGE_PAGE]; // [RQ14]
        next_view[`LPAC_BIT_COMPLY_ACK] = state_reg.next_page[`LPAC_BIT_COMPLY_ACK]; // [RQ15]
        // Toggle is kept exactly as the partner sent it
        next_view[`LPAC_BIT_TOGGLE] = state_reg.next_page[`LPAC_BIT_TOGGLE]; // [RQ16]
        next_view[`LPAC_CODE_MSB-1:0] = state_reg.next_page[`LPAC_CODE_MSB-1:0]; // [RQ14]
        next_view[`LPAC_CODE_MSB] = state_reg.next_page[`LPAC_CODE_MSB]; // [RQ14]
    end

    // The visible word follows the selected view [RQ2]
    assign ability_word = state_reg.view_next ? next_view : base_view;

    // View flips only after completion with next pages enabled and seen;
    // without a taken next page there is nothing newer to show
    assign switch_view = an_complete && state_reg.next_en && state_reg.next_seen; // [RQ2]

    ////////////////////////////////////////////////////////////////////////
    // Event flags and interrupt

    // Events raised by the capture logic
    always_comb begin
        ev_set = '0;
        ev_set[`LPAC_EV_BASE] = word_commit && state_reg.state == LPAC_WAIT_BASE;
        ev_set[`LPAC_EV_NEXT] = word_commit && state_reg.state == LPAC_WAIT_NEXT;
        ev_set[`LPAC_EV_FAULT] = word_commit && state_reg.state == LPAC_WAIT_BASE
            && word_value[`LPAC_BIT_REMOTE_FAULT];
        ev_set[`LPAC_EV_DISCARD] = word_mismatch;
        ev_set[`LPAC_EV_VIEW] = switch_view && !state_reg.view_next;
    end

    // Write-one-to-clear through the clear register
    assign clear_wr = reg_wr && reg_addr == `LPAC_OFF_CLEAR;
    assign ev_clr = clear_wr ? reg_wdata[`LPAC_EV_COUNT-1:0] : '0;

    // One sticky bit per event
    for (genvar i = 0; i < `LPAC_EV_COUNT; i++) begin : g_event
        lpac_event_bit u_bit (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .set_pulse(ev_set[i]),
            .clr_pulse(ev_clr[i]),
            .flag(ev_flag[i])
        );
    end

    // Level interrupt while any enabled flag stands
    // Flags stay set while masked, so a late enable raises the line at once
    assign irq = |(ev_flag & state_reg.irq_en);

    ////////////////////////////////////////////////////////////////////////
    // Capture, control and register port

    always_comb begin
        state_next = state_reg;
        state_next.rdata = '0;

        // Capture sequence of one negotiation
        case (state_reg.state)
            LPAC_WAIT_BASE: begin
                // First consistent word of a negotiation is the base page
                if (word_commit) begin
                    state_next.base_page = word_value; // [RQ17]
                    state_next.next_seen = 1'b0;
                    state_next.state = LPAC_WAIT_NEXT;
                end
            end
            LPAC_WAIT_NEXT: begin
                if (word_commit) begin
                    // Later words are next pages; only whole words land [RQ17]
                    state_next.next_page = word_value;
                    state_next.next_seen = 1'b1;
                end
                if (an_complete) begin
                    state_next.state = LPAC_DONE;
                end
            end
            LPAC_DONE: begin
                // Holds what was negotiated until a restart
                // Late words still pass the filter but are not stored
            end
            default: begin
                state_next.state = LPAC_WAIT_BASE;
            end
        endcase

        // Switch to next page view at completion [RQ2]
        if (switch_view) begin
            state_next.view_next = 1'b1;
        end

        // A restart forgets the old view but keeps the captured words,
        // so software can still inspect the base page of a failed attempt
        if (an_restart) begin
            state_next.state = LPAC_WAIT_BASE;
            state_next.view_next = 1'b0;
            state_next.next_seen = 1'b0;
        end

        // Register writes; the ability offset takes none [RQ1] [RQ5]
        if (reg_wr) begin
            case (reg_addr)
                `LPAC_OFF_ENABLE: begin
                    state_next.irq_en = reg_wdata[`LPAC_EV_COUNT-1:0];
                end
                `LPAC_OFF_CONTROL: begin
                    state_next.next_en = reg_wdata[`LPAC_CTRL_NEXT_EN];
                end
                default: begin
                    // Read-only and unmapped offsets ignore writes
                end
            endcase
        end

        // Register reads answer in the following cycle
        if (reg_rd) begin
            case (reg_addr)
                `LPAC_OFF_ABILITY: begin
                    state_next.rdata = ability_word; // [RQ1]
                end
                `LPAC_OFF_STATUS: begin
                    state_next.rdata = {11'h000, ev_flag};
                end
                `LPAC_OFF_ENABLE: begin
                    state_next.rdata = {11'h000, state_reg.irq_en};
                end
                `LPAC_OFF_CONTROL: begin
                    state_next.rdata = {14'h0000, state_reg.view_next, state_reg.next_en};
                end
                `LPAC_OFF_BASE_SHADOW: begin
                    // Base page stays readable after the view has switched
                    state_next.rdata = base_view;
                end
                default: begin
                    // Clear register and unmapped offsets read as zero
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    // All captured fields reset to zero [RQ3] [RQ4] [RQ13]
    // Interrupt enables reset low so nothing fires before software asks
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg.state <= LPAC_WAIT_BASE;
            state_reg.base_page <= `LPAC_RST_WORD;
            state_reg.next_page <= `LPAC_RST_WORD;
            state_reg.next_seen <= 1'b0;
            state_reg.view_next <= 1'b0;
            state_reg.next_en <= `LPAC_RST_NEXT_EN;
            state_reg.irq_en <= `LPAC_RST_ENABLE;
            state_reg.rdata <= `LPAC_RST_WORD;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Read data stand for exactly one cycle after the strobe
    assign reg_rdata = state_reg.rdata;
    assign view_next = state_reg.view_next;

endmodule : lpac_partner_ability

// *** core/lpac_pkg.sv ***
package lpac_pkg;

    // Capture progress of one negotiation
    typedef enum logic [1:0] {
        LPAC_WAIT_BASE,
        LPAC_WAIT_NEXT,
        LPAC_DONE
    } lpac_state_e;

    // State of the register bank
    typedef struct packed {
        lpac_state_e state;
        logic [15:0] base_page;
        logic [15:0] next_page;
        logic next_seen;
        logic view_next;
        logic next_en;
        logic [4:0] irq_en;
        logic [15:0] rdata;
    } lpac_main_s;

    // State of the word consistency filter
    typedef struct packed {
        logic [15:0] last_word;
        logic [15:0] out_word;
        logic [7:0] count;
        logic taken;
        logic commit;
        logic mismatch;
    } lpac_match_s;

    // State of one sticky event bit
    typedef struct packed {
        logic flag;
    } lpac_event_s;

endpackage : lpac_pkg

// *** core/lpac_word_match.sv ***
`timescale 1ns/1ps
`include "lpac_defines.svh"
module lpac_word_match import lpac_pkg::*; #(
    parameter int MATCH_COUNT = `LPAC_MATCH_COUNT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Decoded words from the pulse bursts
    input wire logic word_valid,
    input wire logic [15:0] word,
    input wire logic restart,
    // Filtered result
    output logic commit,
    output logic [15:0] commit_word,
    output logic mismatch
);

    lpac_match_s state_reg;
    lpac_match_s state_next;

    // The counter is eight bits wide
    if (MATCH_COUNT < 1 || MATCH_COUNT > 255) begin : g_bad_count
        $error("MATCH_COUNT out of range");
    end

    // A word is taken once after MATCH_COUNT identical arrivals [RQ17]
    always_comb begin
        state_next = state_reg;
        state_next.commit = 1'b0;
        state_next.mismatch = 1'b0;
        if (restart) begin
            state_next.count = '0;
            state_next.taken = 1'b0;
        end else if (word_valid) begin
            if (state_reg.count != 8'h00 && word != state_reg.last_word) begin
                // A differing word restarts the count and drops the old one
                state_next.mismatch = !state_reg.taken;
                state_next.count = 8'h01;
                state_next.taken = 1'b0;
            end else if (!state_reg.taken) begin
                state_next.count = state_reg.count + 8'h01;
            end
            state_next.last_word = word;
            if (!state_next.taken && state_next.count == 8'(MATCH_COUNT)) begin
                state_next.commit = 1'b1;
                state_next.taken = 1'b1;
                state_next.out_word = word;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign commit = state_reg.commit;
    assign commit_word = state_reg.out_word;
    assign mismatch = state_reg.mismatch;

endmodule : lpac_word_match

// *** verif/lpac_partner_ability_asserts.sv ***
`timescale 1ns/1ps
module lpac_partner_ability_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Link side and status
    input wire logic [15:0] rx_word,
    input wire logic rx_word_valid,
    input wire logic an_restart,
    input wire logic an_complete,
    input wire logic view_next,
    input wire logic irq
);
    logic ev;
    logic rd_q;
    logic held_ok;
    logic [2:0] quiet_sr;
    logic [15:0] held_val;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // Read request at one address
    sequence rd_at(logic [4:0] a);
        reg_rd && reg_addr == a;
    endsequence

    // Anything that may legally change the ability word
    assign ev = rx_word_valid || an_restart || an_complete;

    // Last quiet read of the ability word; a window of three edges covers commit latency
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_sr <= 3'b000;
            rd_q <= 1'b0;
            held_ok <= 1'b0;
            held_val <= 16'h0000;
        end else begin
            quiet_sr <= {quiet_sr[1:0], ev};
            rd_q <= reg_rd && reg_addr == 5'h05;
            if (ev) begin
                held_ok <= 1'b0;
            end else if (rd_q && quiet_sr == 3'b000) begin
                held_ok <= 1'b1;
                held_val <= reg_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    view_rise_a: assert property ($rose(view_next) |-> $past(an_complete))
        else $error("view switched without completion");
    view_clear_a: assert property (an_restart |=> !view_next)
        else $error("view not back to base after restart");
    view_hold_a: assert property (!an_complete && !an_restart |=> $stable(view_next))
        else $error("view changed on its own");
    base_rsvd_a: assert property (rd_at(5'h05) ##0 !view_next |=> reg_rdata[12] == 1'b0)
        else $error("reserved bit set in base view");
    unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {5'h05, [5'h10:5'h14]})
        |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    clear_read_a: assert property (rd_at(5'h12) |=> reg_rdata == 16'h0000)
        else $error("clear register read not zero");
    word_stable_a: assert property (rd_q && quiet_sr == 3'b000 && held_ok |-> reg_rdata == held_val)
        else $error("ability word changed without a received word");
endmodule : lpac_partner_ability_asserts

bind lpac_partner_ability lpac_partner_ability_asserts lpac_partner_ability_asserts_i (.*);

// *** verif/lpac_partner_model.sv ***
`timescale 1ns/1ps
module lpac_partner_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Command from the bench
    input wire logic go,
    input wire logic [15:0] word,
    input wire logic [3:0] reps,
    input wire logic slow,
    // Decoded words towards the block
    output logic [15:0] rx_word,
    output logic rx_word_valid,
    output logic busy
);
    logic [3:0] left;
    logic gap;
    logic [15:0] hold;

    ////////////////////////////////////////////////////////////////////////
    // One word per burst; idle cycles show the inverse so stale data never reads as fresh
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 4'h0;
            gap <= 1'b0;
            hold <= 16'h0000;
            rx_word <= 16'hFFFF;
            rx_word_valid <= 1'b0;
        end else begin
            rx_word_valid <= 1'b0;
            rx_word <= ~hold;
            if (go) begin
                hold <= word;
                left <= reps;
            end else if (left != 4'h0 && !gap) begin
                rx_word <= hold;
                rx_word_valid <= 1'b1;
                left <= left - 4'h1;
                gap <= slow; // Slow partner leaves a quiet cycle between bursts
            end else begin
                gap <= 1'b0;
            end
        end
    end

    // Busy while repeats remain
    assign busy = (left != 4'h0);
endmodule : lpac_partner_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic ref_clk;
    logic rst_b;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [15:0] rx_word;
    logic rx_word_valid;
    logic an_restart;
    logic an_complete;
    logic view_next;
    logic irq;
    logic lp_go;
    logic [15:0] lp_word;
    logic [3:0] lp_reps;
    logic lp_slow;
    logic lp_busy;
    int failures = 0;
    int cmp_count = 0;

    ////////////////////////////////////////////////////////////////////////
    lpac_partner_ability #(.MATCH_COUNT(3)) lpac_partner_ability_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .an_restart(an_restart), .an_complete(an_complete), .view_next(view_next), .irq(irq));
    lpac_partner_model lpac_partner_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .go(lp_go),
        .word(lp_word), .reps(lp_reps), .slow(lp_slow), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .busy(lp_busy));

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : step

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // Partner repeats a word; three quiet edges let the commit land
    task automatic send(input logic [15:0] w, input logic [3:0] n, input logic s);
        int k;
        @(posedge ref_clk);
        lp_word <= w;
        lp_reps <= n;
        lp_slow <= s;
        lp_go <= 1'b1;
        @(posedge ref_clk);
        lp_go <= 1'b0;
        #1;
        for (k = 0; k < 64 && lp_busy === 1'b1; k++) begin
            @(posedge ref_clk);
        end
        step(3);
    endtask : send

    task automatic pulse_an(input logic restart);
        @(posedge ref_clk);
        an_restart <= restart;
        an_complete <= !restart;
        @(posedge ref_clk);
        an_restart <= 1'b0;
        an_complete <= 1'b0;
        #1;
    endtask : pulse_an

    // Reset held ten cycles, then every captured field reads zero
    task automatic t_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        step(10);
        rst_b <= 1'b1;
        rd(5'h05, 16'h0000);
        rd(5'h13, 16'h0001);
        rd(5'h10, 16'h0000);
        rd(5'h1F, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    // Base page with every ability set, write attempt, interrupt raise and clear
    task automatic t_base();
        wr(5'h11, 16'h001F);
        send(16'hFFFF, 4'h3, 1'b0);
        rd(5'h05, 16'hEFFF);
        wr(5'h05, 16'h0000);
        rd(5'h05, 16'hEFFF);
        rd(5'h10, 16'h0005);
        chk({15'h0000, irq}, 16'h0001);
        wr(5'h12, 16'h001F);
        rd(5'h10, 16'h0000);
        rd(5'h12, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        $display("test base done");
    endtask : t_base

    // Short runs are discarded, then a next page replaces the view on completion
    task automatic t_next();
        send(16'h0041, 4'h2, 1'b0);
        send(16'h0021, 4'h2, 1'b0);
        rd(5'h05, 16'hEFFF);
        send(16'hB805, 4'h3, 1'b1);
        rd(5'h05, 16'hEFFF);
        rd(5'h10, 16'h000A);
        pulse_an(1'b0);
        chk({15'h0000, view_next}, 16'h0001);
        rd(5'h05, 16'hB805);
        rd(5'h14, 16'hEFFF);
        rd(5'h13, 16'h0003);
        rd(5'h10, 16'h001A);
        wr(5'h11, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        wr(5'h12, 16'h001F);
        pulse_an(1'b1);
        chk({15'h0000, view_next}, 16'h0000);
        rd(5'h05, 16'hEFFF);
        $display("test next done");
    endtask : t_next

    // Next pages disabled: completion keeps the base view
    task automatic t_np_off();
        wr(5'h13, 16'h0000);
        send(16'h01E1, 4'h3, 1'b0);
        send(16'h2123, 4'h3, 1'b0);
        pulse_an(1'b0);
        chk({15'h0000, view_next}, 16'h0000);
        rd(5'h05, 16'h01E1);
        $display("test np_off done");
    endtask : t_np_off

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    // Main sequence, second reset at the end included
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        an_restart = 1'b0;
        an_complete = 1'b0;
        lp_go = 1'b0;
        lp_word = 16'h0000;
        lp_reps = 4'h0;
        lp_slow = 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_base();
        t_next();
        t_np_off();
        t_reset();
        end_sim();
    end

    // Watchdog well beyond the roughly 130 cycles the tests need
    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule : testbench
